// ---- eps_pkg.sv ----
// shared constants for the e-paper power and refresh sequencer
package eps_pkg;
    // command codes
    localparam logic [7:0] CMD_POWER_DOWN    = 8'h02;
    localparam logic [7:0] CMD_POWER_SEQ     = 8'h03;
    localparam logic [7:0] CMD_POWER_UP      = 8'h04;
    localparam logic [7:0] CMD_SOFT_START    = 8'h06;
    localparam logic [7:0] CMD_SLEEP_ENTRY   = 8'h07;
    localparam logic [7:0] CMD_PIXEL_WRITE   = 8'h10;
    localparam logic [7:0] CMD_REFRESH       = 8'h12;
    localparam logic [7:0] CMD_AUTO_SEQ      = 8'h17;
    localparam logic [7:0] CMD_SCAN_RATE     = 8'h30;
    localparam logic [7:0] SLEEP_CHECK       = 8'ha5;
    localparam logic [7:0] AUTO_PLAIN        = 8'ha5;
    localparam logic [7:0] AUTO_WITH_SLEEP   = 8'ha7;
    // reset values
    localparam logic [7:0] POWER_SEQ_RST     = 8'h00;
    localparam logic [7:0] SOFT_START_A_RST  = 8'h0f;
    localparam logic [7:0] SOFT_START_B_RST  = 8'h8b;
    localparam logic [7:0] SOFT_START_C_RST  = 8'h93;
    localparam logic [7:0] SOFT_START_D_RST  = 8'ha3;
    localparam logic [7:0] SCAN_RATE_RST     = 8'h02;
    localparam logic [7:0] POLARITY_RST      = 8'h01;
    // field positions
    localparam int GATE_OFF_LSB   = 4;
    localparam int SOURCE_OFF_LSB = 0;
    localparam int PHASE_A_LSB    = 2;
    localparam int PHASE_B_LSB    = 0;
    localparam int DYN_RATE_BIT   = 3;
    // timing
    localparam int CLK_HZ         = 40000000;
    localparam int STEP_MS        = 10;
    localparam int STEP_CYCLES    = CLK_HZ / 1000 * STEP_MS;
    localparam int REFRESH_STEPS  = 4;
endpackage

// ---- eps_sequencer.sv ----
// command interpreter with power, refresh and sleep sequencing
`timescale 1ns/1ps
// What this block does
// - power sequence command 03 takes one byte, resets to zero
// - bits 5:4 set gate-off delay 20/40/60/80 ms
// - bits 1:0 set source-off delay 20/40/60/80 ms
// - power-up command 04 runs power-on, busy low throughout
// - power-on enables booster and source rails, over 120 ms by default
// - soft start 06 takes four bytes; first byte holds phase A/B durations
// - phase codes 00..11 give 10, 20, 30, 40 ms in phase A, 50, 60, 70, 80 ms in phase B
// - first byte bits 6:4 reserved max on-time, default 000
// - bytes two to four bits 6:4 are phase strengths
// - bytes two to four bits 3:0 are phase minimum off-times
// - sleep command 07 enters deep sleep only with check A5
// - deep sleep is left only through hardware reset
// - pixel write 10 stores bytes, four pixels, first in top bits
// - pixel codes map to gray directly, or inverted when polarity zero
// - refresh drives panel from frame memory, busy low throughout
// - auto 17: A5 on/refresh/off, A7 adds sleep, others ignored
// - busy stays low through whole auto sequence
// - scan rate 30 byte resets to 2, bit 3 dynamic rate
// - bits 2:0 select scan rate 12.5 to 85 Hz
// - power-down 02 shuts rails keeping memory, only when powered on
module eps_sequencer #(
    parameter int MEM_DEPTH  = 64,
    parameter int STEP_COUNT = eps_pkg::STEP_CYCLES
) (
    // system
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // serial link
    input  wire logic        link_clk,
    input  wire logic        link_cs_n,
    input  wire logic        link_dc,
    input  wire logic        link_sda,
    // status
    output logic             busy_n,
    output logic             booster_on,
    output logic             source_on,
    output logic             deep_sleep,
    output logic             panel_drive,
    output logic [1:0]       gray_level,
    output logic [2:0]       scan_rate_sel,
    output logic             dyn_rate_en,
    output logic [7:0]       soft_start_cfg
);
    localparam int AW = $clog2(MEM_DEPTH);
    initial
    begin
        // address counters wrap, so the depth must be a power of two
        if (MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0 || STEP_COUNT < 2)
            $error("eps_sequencer: bad parameter");
    end

    // link domain: shift bytes, toggle on each completed byte
    logic [2:0] bitcnt_ff;
    logic [6:0] shift_ff;
    logic [8:0] lbyte_ff;
    logic       ltog_ff;
    always_ff @(posedge link_clk or posedge link_cs_n)
    begin
        if (link_cs_n)
            bitcnt_ff <= 3'h0;
        else
            bitcnt_ff <= bitcnt_ff + 3'h1;
    end
    always_ff @(posedge link_clk)
    begin
        shift_ff <= {shift_ff[5:0], link_sda};
        if (!link_cs_n && bitcnt_ff == 3'h7)
            lbyte_ff <= {link_dc, shift_ff, link_sda};
    end
    // cleared with the synchroniser so a reset never replays the last byte;
    // link clock stands still while idle, so the release is quiet
    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
            ltog_ff <= 1'b0;
        else if (!link_cs_n && bitcnt_ff == 3'h7)
            ltog_ff <= ~ltog_ff;
    end

    // crossing: toggle through two flops, word held stable meanwhile
    logic [2:0] tsync_ff;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tsync_ff <= 3'h0;
        else
            tsync_ff <= {tsync_ff[1:0], ltog_ff};
    end
    logic       byte_stb;
    logic       is_param;
    logic [7:0] rx;
    assign byte_stb = tsync_ff[2] ^ tsync_ff[1];
    assign is_param = lbyte_ff[8];
    assign rx       = lbyte_ff[7:0];

    // configuration
    logic [7:0]  cmd_ff;
    logic [2:0]  pidx_ff;
    logic [7:0]  pseq_ff;
    logic [31:0] sstart_ff;
    logic [7:0]  rate_ff;
    logic        polarity_ff;
    logic [AW-1:0] waddr_ff;
    logic [7:0]  mem [MEM_DEPTH];
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cmd_ff    <= 8'h00;
            pidx_ff   <= 3'h0;
            pseq_ff   <= eps_pkg::POWER_SEQ_RST;
            sstart_ff <= {eps_pkg::SOFT_START_A_RST, eps_pkg::SOFT_START_B_RST,
                          eps_pkg::SOFT_START_C_RST, eps_pkg::SOFT_START_D_RST};
            rate_ff   <= eps_pkg::SCAN_RATE_RST;
            polarity_ff <= eps_pkg::POLARITY_RST[0];
            waddr_ff  <= '0;
        end
        else if (byte_stb && !deep_sleep)
        begin
            if (!is_param)
            begin
                cmd_ff   <= rx;
                pidx_ff  <= 3'h0;
                if (rx == eps_pkg::CMD_PIXEL_WRITE)
                    waddr_ff <= '0;
            end
            else
            begin
                if (pidx_ff != 3'h7)
                    pidx_ff <= pidx_ff + 3'h1;
                case (cmd_ff)
                    eps_pkg::CMD_POWER_SEQ:
                        if (pidx_ff == 3'h0)
                            pseq_ff <= rx & 8'h33;
                    eps_pkg::CMD_SOFT_START:
                        if (pidx_ff < 3'h4)
                            sstart_ff[8*(3-pidx_ff[1:0]) +: 8] <=
                                (pidx_ff == 3'h0) ? (rx & 8'h7f) : (rx | 8'h80);
                    eps_pkg::CMD_SCAN_RATE:
                        if (pidx_ff == 3'h0)
                            rate_ff <= rx & 8'h0f;
                    eps_pkg::CMD_PIXEL_WRITE:
                    begin
                        mem[waddr_ff] <= rx;
                        waddr_ff <= waddr_ff + 1'b1;
                    end
                    default:
                        ;
                endcase
            end
        end
    end

    // sequencer states
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_PH_A   = 6'b000010,
        S_PH_B   = 6'b000100,
        S_REFR   = 6'b001000,
        S_OFF    = 6'b010000,
        S_SLEEP  = 6'b100000
    } eps_state_t;
    eps_state_t state_ff;
    logic [31:0] tick_ff;
    logic [4:0]  steps_ff;
    logic        auto_ff;
    logic        auto_sleep_ff;
    logic        powered_ff;
    logic        step_end;
    assign step_end = (tick_ff == STEP_COUNT - 1);

    function automatic logic [4:0] phase_steps(input logic [1:0] code);
        phase_steps = {3'h0, code} + 5'h1;
    endfunction
    function automatic logic [4:0] off_steps(input logic [1:0] code);
        off_steps = ({3'h0, code} + 5'h1) << 1;
    endfunction

    logic cmd_strobe;
    logic prm_strobe;
    assign cmd_strobe = byte_stb && !is_param;
    assign prm_strobe = byte_stb && is_param;
    logic done_step;
    assign done_step = step_end && steps_ff == 5'h1;

    always_ff @(posedge sys_clk)
    begin
        if (reset || state_ff == S_IDLE)
            tick_ff <= 32'h0;
        else if (step_end)
            tick_ff <= 32'h0;
        else
            tick_ff <= tick_ff + 32'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff      <= S_IDLE;
            steps_ff      <= 5'h0;
            auto_ff       <= 1'b0;
            auto_sleep_ff <= 1'b0;
            powered_ff    <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                    if (cmd_strobe && rx == eps_pkg::CMD_POWER_UP && !powered_ff)
                    begin
                        state_ff <= S_PH_A;
                        steps_ff <= phase_steps(sstart_ff[24+eps_pkg::PHASE_A_LSB +: 2]);
                    end
                    else if (cmd_strobe && rx == eps_pkg::CMD_POWER_DOWN && powered_ff)
                    begin
                        state_ff <= S_OFF;
                        steps_ff <= off_steps(pseq_ff[eps_pkg::GATE_OFF_LSB +: 2])
                                  + off_steps(pseq_ff[eps_pkg::SOURCE_OFF_LSB +: 2]);
                    end
                    else if (cmd_strobe && rx == eps_pkg::CMD_REFRESH)
                    begin
                        state_ff <= S_REFR;
                        steps_ff <= 5'(eps_pkg::REFRESH_STEPS);
                    end
                    else if (prm_strobe && cmd_ff == eps_pkg::CMD_SLEEP_ENTRY
                             && pidx_ff == 3'h0 && rx == eps_pkg::SLEEP_CHECK)
                        state_ff <= S_SLEEP;
                    else if (prm_strobe && cmd_ff == eps_pkg::CMD_AUTO_SEQ && pidx_ff == 3'h0
                             && (rx == eps_pkg::AUTO_PLAIN || rx == eps_pkg::AUTO_WITH_SLEEP))
                    begin
                        auto_ff       <= 1'b1;
                        auto_sleep_ff <= (rx == eps_pkg::AUTO_WITH_SLEEP);
                        state_ff      <= S_PH_A;
                        steps_ff <= phase_steps(sstart_ff[24+eps_pkg::PHASE_A_LSB +: 2]);
                    end
                S_PH_A:
                    if (done_step)
                    begin
                        state_ff <= S_PH_B;
                        steps_ff <= phase_steps(sstart_ff[24+eps_pkg::PHASE_B_LSB +: 2]) + 5'h4;
                    end
                    else if (step_end)
                        steps_ff <= steps_ff - 5'h1;
                S_PH_B:
                    if (done_step)
                    begin
                        powered_ff <= 1'b1;
                        if (auto_ff)
                        begin
                            state_ff <= S_REFR;
                            steps_ff <= 5'(eps_pkg::REFRESH_STEPS);
                        end
                        else
                            state_ff <= S_IDLE;
                    end
                    else if (step_end)
                        steps_ff <= steps_ff - 5'h1;
                S_REFR:
                    if (done_step)
                    begin
                        if (auto_ff)
                        begin
                            state_ff <= S_OFF;
                            steps_ff <= off_steps(pseq_ff[eps_pkg::GATE_OFF_LSB +: 2])
                                      + off_steps(pseq_ff[eps_pkg::SOURCE_OFF_LSB +: 2]);
                        end
                        else
                            state_ff <= S_IDLE;
                    end
                    else if (step_end)
                        steps_ff <= steps_ff - 5'h1;
                S_OFF:
                    if (done_step)
                    begin
                        powered_ff <= 1'b0;
                        auto_ff    <= 1'b0;
                        state_ff   <= (auto_ff && auto_sleep_ff) ? S_SLEEP : S_IDLE;
                    end
                    else if (step_end)
                        steps_ff <= steps_ff - 5'h1;
                S_SLEEP:
                    state_ff <= S_SLEEP;
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // pixel readout during refresh
    logic [AW-1:0] raddr_ff;
    logic [1:0]    pix_ff;
    logic [1:0]    code;
    assign code = mem[raddr_ff][7 - 2*pix_ff -: 2];
    always_ff @(posedge sys_clk)
    begin
        if (reset || state_ff != S_REFR)
        begin
            raddr_ff <= '0;
            pix_ff   <= 2'h0;
        end
        else
        begin
            pix_ff <= pix_ff + 2'h1;
            if (pix_ff == 2'h3)
                raddr_ff <= (raddr_ff == AW'(MEM_DEPTH - 1)) ? '0 : raddr_ff + 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            busy_n         <= 1'b1;
            booster_on     <= 1'b0;
            source_on      <= 1'b0;
            deep_sleep     <= 1'b0;
            panel_drive    <= 1'b0;
            gray_level     <= 2'h0;
            scan_rate_sel  <= eps_pkg::SCAN_RATE_RST[2:0];
            dyn_rate_en    <= 1'b0;
            soft_start_cfg <= 8'h00;
        end
        else
        begin
            busy_n      <= (state_ff == S_IDLE) || (state_ff == S_SLEEP);
            booster_on  <= (state_ff == S_PH_A) || (state_ff == S_PH_B) || powered_ff;
            source_on   <= (state_ff == S_PH_B) || powered_ff;
            deep_sleep  <= (state_ff == S_SLEEP);
            panel_drive <= (state_ff == S_REFR);
            gray_level  <= polarity_ff ? code : ~code;
            scan_rate_sel <= rate_ff[2:0];
            dyn_rate_en   <= rate_ff[eps_pkg::DYN_RATE_BIT];
            soft_start_cfg <= (state_ff == S_PH_A) ? sstart_ff[23:16] :
                              (state_ff == S_PH_B) ? sstart_ff[15:8] : sstart_ff[7:0];
        end
    end

    // checks
    property p_busy_low_seq;
        @(posedge sys_clk) disable iff (reset)
        (state_ff != S_IDLE && state_ff != S_SLEEP) |=> !busy_n;
    endproperty
    a_busy_low_seq: assert property (p_busy_low_seq) else $error("busy high in op");
    property p_sleep_stays;
        @(posedge sys_clk) disable iff (reset)
        deep_sleep |=> deep_sleep;
    endproperty
    a_sleep_stays: assert property (p_sleep_stays) else $error("left sleep");
    property p_bad_check;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == S_IDLE && prm_strobe && cmd_ff == eps_pkg::CMD_SLEEP_ENTRY
         && rx != eps_pkg::SLEEP_CHECK) |=> state_ff != S_SLEEP;
    endproperty
    a_bad_check: assert property (p_bad_check) else $error("sleep on bad code");
    property p_off_needs_power;
        @(posedge sys_clk) disable iff (reset)
        (state_ff == S_IDLE && !powered_ff) |=> state_ff != S_OFF;
    endproperty
    a_off_needs_power: assert property (p_off_needs_power) else $error("off unpowered");
    property p_rate_follow;
        @(posedge sys_clk) disable iff (reset)
        ##1 scan_rate_sel == $past(rate_ff[2:0]);
    endproperty
    a_rate_follow: assert property (p_rate_follow) else $error("rate mismatch");
    property p_auto_busy;
        @(posedge sys_clk) disable iff (reset)
        (auto_ff && state_ff != S_IDLE) |=> !busy_n;
    endproperty
    a_auto_busy: assert property (p_auto_busy) else $error("busy in auto");
    property p_source_power;
        @(posedge sys_clk) disable iff (reset)
        $rose(powered_ff) |=> source_on && booster_on;
    endproperty
    a_source_power: assert property (p_source_power) else $error("rails off");
    property p_refr_drive;
        @(posedge sys_clk) disable iff (reset)
        $rose(state_ff == S_REFR) |=> panel_drive;
    endproperty
    a_refr_drive: assert property (p_refr_drive) else $error("no drive");
    c_sleep: cover property (@(posedge sys_clk) disable iff (reset) $rose(deep_sleep));
    c_auto: cover property (@(posedge sys_clk) disable iff (reset) $rose(auto_ff));
    c_power: cover property (@(posedge sys_clk) disable iff (reset) $rose(powered_ff));
endmodule

// ---- eps_host_model.sv ----
// host model that drives command and parameter bytes over the serial link
`timescale 1ns/1ps
module eps_host_model (
    // serial link
    output logic link_clk,
    output logic link_cs_n,
    output logic link_dc,
    output logic link_sda
);
    initial
    begin
        link_clk  = 1'b0;
        link_cs_n = 1'b1;
        link_dc   = 1'b1;
        link_sda  = 1'b1;
    end
    // one byte, msb first; clock stands still outside the frame
    task automatic send_byte(input logic dc, input logic [7:0] data);
        #400;
        link_cs_n = 1'b0;
        link_dc   = dc;
        for (int i = 7; i >= 0; i--)
        begin
            link_sda = data[i];
            #80;
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
        end
        link_cs_n = 1'b1;
        // released lines show the inverse of their last value
        link_dc   = ~dc;
        link_sda  = ~data[0];
    endtask
endmodule

// ---- test_epaper_power_refresh_sequencer.sv ----
// self-checking bench for the power and refresh sequencer
`timescale 1ns/1ps
module test_epaper_power_refresh_sequencer;
    localparam int S = 4;
    logic       sys_clk = 1'b0;
    logic       reset   = 1'b1;
    logic       link_clk, link_cs_n, link_dc, link_sda;
    logic       busy_n, booster_on, source_on, deep_sleep, panel_drive, dyn_rate_en;
    logic [1:0] gray_level;
    logic [2:0] scan_rate_sel;
    logic [7:0] soft_start_cfg;
    logic [7:0] first_cfg;
    logic       first_boost, first_drive;
    logic [1:0] first_gray;
    int         n_mismatch = 0;
    int         compares = 0;
    int         n;

    always #12.5 sys_clk = ~sys_clk;

    eps_host_model u_host (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_dc(link_dc),
                           .link_sda(link_sda));
    eps_sequencer #(.MEM_DEPTH(64), .STEP_COUNT(S)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .link_cs_n(link_cs_n),
        .link_dc(link_dc), .link_sda(link_sda), .busy_n(busy_n), .booster_on(booster_on),
        .source_on(source_on), .deep_sleep(deep_sleep), .panel_drive(panel_drive),
        .gray_level(gray_level), .scan_rate_sel(scan_rate_sel), .dyn_rate_en(dyn_rate_en),
        .soft_start_cfg(soft_start_cfg));

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_len(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic send(input logic dc, input logic [7:0] b);
        u_host.send_byte(dc, b);
        repeat (6) @(negedge sys_clk);
    endtask
    // counts one unbroken busy span; zero when busy never falls
    task automatic busy_span(output int len);
        int w;
        w = 0;
        len = 0;
        while (busy_n !== 1'b0 && w < 150)
        begin
            @(negedge sys_clk);
            w++;
        end
        while (busy_n === 1'b0 && len < 3000)
        begin
            len++;
            if (len == 2)
            begin
                first_cfg   = soft_start_cfg;
                first_boost = booster_on;
                first_drive = panel_drive;
                first_gray  = gray_level;
            end
            @(negedge sys_clk);
        end
    endtask
    task automatic long(input logic dc, input logic [7:0] b, output int len);
        fork
            u_host.send_byte(dc, b);
            busy_span(len);
        join
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic t_reset_values();
        chk_vec("busy_n", 8'h01, {7'h00, busy_n});
        chk_vec("rails", 8'h00, {6'h00, booster_on, source_on});
        chk_vec("scan_rate", 8'h02, {4'h0, dyn_rate_en, scan_rate_sel});
    endtask
    task automatic t_scan_rate();
        for (int r = 0; r < 6; r++)
        begin
            send(1'b0, eps_pkg::CMD_SCAN_RATE);
            send(1'b1, 8'(r) | (r[0] ? 8'h08 : 8'h00));
            chk_vec("scan_rate", 8'(r) | (r[0] ? 8'h08 : 8'h00),
                    {4'h0, dyn_rate_en, scan_rate_sel});
        end
    endtask
    task automatic t_power_up_default();
        long(1'b0, eps_pkg::CMD_POWER_DOWN, n);
        chk_len("power_down_while_off", 0, 0, n);
        long(1'b0, eps_pkg::CMD_POWER_UP, n);
        chk_len("power_up_default", 12 * S, 12 * S + 3, n);
        chk_vec("phase_a_cfg", eps_pkg::SOFT_START_B_RST, first_cfg);
        chk_vec("rails_on", 8'h03, {6'h00, first_boost, source_on});
    endtask
    task automatic t_refresh();
        send(1'b0, eps_pkg::CMD_PIXEL_WRITE);
        send(1'b1, 8'h6c);
        send(1'b1, 8'hff);
        long(1'b0, eps_pkg::CMD_REFRESH, n);
        chk_len("refresh", 4 * S, 4 * S + 3, n);
        // second pixel of the first byte, code 10, shows as gray 2
        chk_vec("panel_gray", 8'h06, {5'h00, first_drive, first_gray});
    endtask
    task automatic t_power_down_seq();
        send(1'b0, eps_pkg::CMD_POWER_SEQ);
        send(1'b1, 8'h31);
        long(1'b0, eps_pkg::CMD_POWER_DOWN, n);
        chk_len("power_down_80_40", 12 * S, 12 * S + 3, n);
        chk_vec("rails_off", 8'h00, {6'h00, booster_on, source_on});
    endtask
    task automatic t_soft_start();
        send(1'b0, eps_pkg::CMD_SOFT_START);
        send(1'b1, 8'h71);
        send(1'b1, 8'h95);
        send(1'b1, 8'ha6);
        send(1'b1, 8'hb7);
        long(1'b0, eps_pkg::CMD_POWER_UP, n);
        chk_len("power_up_short", 7 * S, 7 * S + 3, n);
        chk_vec("phase_a_cfg", 8'h95, first_cfg);
        chk_vec("idle_cfg", 8'hb7, soft_start_cfg);
    endtask
    task automatic t_auto();
        send(1'b0, eps_pkg::CMD_AUTO_SEQ);
        long(1'b1, 8'h55, n);
        chk_len("auto_other", 0, 0, n);
        send(1'b0, eps_pkg::CMD_AUTO_SEQ);
        long(1'b1, eps_pkg::AUTO_PLAIN, n);
        chk_len("auto_plain", 23 * S, 23 * S + 8, n);
        chk_vec("auto_end", 8'h01, {5'h00, booster_on, deep_sleep, busy_n});
    endtask
    task automatic t_sleep();
        send(1'b0, eps_pkg::CMD_SLEEP_ENTRY);
        send(1'b1, 8'h5a);
        chk_vec("sleep_bad_code", 8'h00, {7'h00, deep_sleep});
        send(1'b0, eps_pkg::CMD_SLEEP_ENTRY);
        send(1'b1, eps_pkg::SLEEP_CHECK);
        chk_vec("sleep_entry", 8'h01, {7'h00, deep_sleep});
        long(1'b0, eps_pkg::CMD_POWER_UP, n);
        chk_len("wake_by_command", 0, 0, n);
        do_reset();
        chk_vec("wake_by_reset", 8'h00, {7'h00, deep_sleep});
        send(1'b0, eps_pkg::CMD_AUTO_SEQ);
        long(1'b1, eps_pkg::AUTO_WITH_SLEEP, n);
        chk_len("auto_sleep", 20 * S, 20 * S + 8, n);
        chk_vec("auto_sleep_end", 8'h01, {7'h00, deep_sleep});
    endtask

    initial
    begin
        #500000;
        n_mismatch++;
        $display("[ERR] watchdog expected done seen timeout");
        complete_run();
    end
    initial
    begin
        do_reset();
        t_reset_values();
        t_scan_rate();
        t_power_up_default();
        t_refresh();
        t_power_down_seq();
        t_soft_start();
        t_auto();
        t_sleep();
        complete_run();
    end
endmodule
